// ==== verif/dzc_ctrl_model.sv ====
// Controller model: link clock, select, clock enable and CA bus.
// Assumes the bench calls send once per whole two-edge frame.
`timescale 1ns/1ps
module dzc_ctrl_model (
  output logic                     ck,
  output logic                     cs_n,
  output logic                     cke,
  output logic [dzc_pkg::CA_W-1:0] ca
);
  initial begin
    ck   = 1'b0;
    cs_n = 1'b1;
    cke  = 1'b1;
    ca   = 10'h000;
  end
  // Clock stands low between frames; bench keeps order
  // Bench opens no bank and no termination here
  // No phase shift modelled, so no irregular periods
  task automatic send(
    input logic [9:0] r,
    input logic [9:0] f,
    input logic       sel,
    input logic       en
  );
    cs_n = ~sel;
    cke  = en;   // High for all but the refused remap
    ca   = r;    // Held long before and after each edge
    #32 ck = 1'b1;
    #16 ca = f;
    #16 ck = 1'b0;
    #16 ca = ~f; // Released bus must not look stable
    cs_n = 1'b1;
    cke  = 1'b1;
    #16;
  endtask : send
endmodule : dzc_ctrl_model

// ==== verif/dzc_top_asserts.sv ====
// Port-level checker for the calibration and training decoder.
// Assumes it is bound to dzc_top and sees only its ports.
`timescale 1ns/1ps
module dzc_top_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  input wire logic        dqs_o,
  input wire logic        dqs_oe,
  input wire logic        impedance_ref_pin_en,
  input wire logic        cal_busy,
  input wire logic        cal_at_default,
  input wire logic        training_active,
  input wire logic        training_remap,
  input wire logic        mode_regs_reset,
  input wire logic        illegal_cmd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_strobe_static;
    dqs_o == 1'b0 && dqs_oe == 1'b0;
  endproperty
  a_strobe_static: assert property (p_strobe_static)
    else $error("strobe moved");
  property p_lanes_driven;
    dq_oe == {16{training_active}};
  endproperty
  a_lanes_driven: assert property (p_lanes_driven)
    else $error("lane enables wrong");
  property p_pin_off;
    impedance_ref_pin_en == cal_busy;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin circuit on while idle");
  property p_remap_inside;
    training_remap |-> training_active;
  endproperty
  a_remap_inside: assert property (p_remap_inside)
    else $error("remap outside training");
  property p_idle_lanes;
    !training_active |-> dq_o == 16'h0000;
  endproperty
  a_idle_lanes: assert property (p_idle_lanes)
    else $error("echo data outside training");
  property p_reset_write;
    mode_regs_reset |=> !mode_regs_reset && cal_at_default && !cal_busy;
  endproperty
  a_reset_write: assert property (p_reset_write)
    else $error("reset write effect wrong");
  property p_refuse_pulse;
    illegal_cmd |=> !illegal_cmd;
  endproperty
  a_refuse_pulse: assert property (p_refuse_pulse)
    else $error("refusal not a pulse");
  property p_cal_min;
    $rose(cal_busy) |-> cal_busy [*8];
  endproperty
  a_cal_min: assert property (p_cal_min)
    else $error("calibration too short");
  property p_cal_max;
    $rose(cal_busy) |-> ##[10:200] !cal_busy;
  endproperty
  a_cal_max: assert property (p_cal_max)
    else $error("calibration never ends");
endmodule : dzc_top_asserts
bind dzc_top dzc_top_asserts i_dzc_top_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .dq_o(dq_o), .dq_oe(dq_oe),
  .dqs_o(dqs_o), .dqs_oe(dqs_oe), .cal_busy(cal_busy),
  .impedance_ref_pin_en(impedance_ref_pin_en),
  .cal_at_default(cal_at_default), .training_active(training_active),
  .training_remap(training_remap), .mode_regs_reset(mode_regs_reset),
  .illegal_cmd(illegal_cmd)
);

// ==== verif/dzc_top_tb.sv ====
// Self-checking bench for the calibration and training decoder.
// Assumes the controller model spaces whole frames on the link.
`timescale 1ns/1ps
module dzc_top_tb;
  typedef struct packed {
    logic        rm;
    logic [9:0]  r;
    logic [9:0]  f;
    logic [15:0] dq;
  } dzc_row_t;
  typedef struct packed {
    logic [9:0] f;
    logic [9:0] cyc;
    logic       dflt;
  } dzc_cal_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, banks_open = 1'b0;
  logic ck, cs_n, cke, dqs_o, dqs_oe, impedance_ref_pin_en, cal_busy;
  logic cal_at_default, training_active, training_remap;
  logic mode_regs_reset, illegal_cmd;
  logic [9:0]  cmd_addr_bus, last_len;
  logic [15:0] dq_o, dq_oe;
  int fail_count = 0, num_checks = 0, ill_n = 0, mrr_n = 0;
  int ends_n = 0, run = 0;
  dzc_cal_t cal_tab [4] = '{'{10'h3FC, dzc_pkg::INIT_IMPEDANCE_CAL_CYC, 1'b0},
    '{10'h2AC, dzc_pkg::LONG_IMPEDANCE_CAL_CYC, 1'b0}, '{10'h158, dzc_pkg::SHORT_IMPEDANCE_CAL_CYC, 1'b0},
    '{10'h30C, dzc_pkg::IMPEDANCE_CAL_RESET_CYC, 1'b1}};
  // Hand-worked echo words: primary rows, then remapped rows
  dzc_row_t tab [6] = '{'{1'b0, 10'h3FF, 10'h000, 16'h5555},
    '{1'b0, 10'h000, 10'h3FF, 16'hAAAA}, '{1'b0, 10'h00F, 10'h1E0, 16'hAA55},
    '{1'b0, 10'h010, 10'h200, 16'h0000}, '{1'b1, 10'h010, 10'h200, 16'h0201},
    '{1'b1, 10'h3EF, 10'h1FF, 16'h0102}};
  always #2.5 clk_sys = ~clk_sys;
  dzc_ctrl_model i_dzc_ctrl_model (.ck(ck), .cs_n(cs_n), .cke(cke),
    .ca(cmd_addr_bus));
  dzc_top i_dzc_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .diff_clock_true(ck), .cs_n(cs_n), .cke(cke),
    .cmd_addr_bus(cmd_addr_bus), .banks_open(banks_open), .dq_o(dq_o),
    .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .impedance_ref_pin_en(impedance_ref_pin_en), .cal_busy(cal_busy),
    .cal_at_default(cal_at_default), .training_active(training_active),
    .training_remap(training_remap), .mode_regs_reset(mode_regs_reset),
    .illegal_cmd(illegal_cmd));
  // Pulses and busy lengths are counted here so no pulse is missed
  always @(posedge clk_sys) begin
    if (illegal_cmd === 1'b1) ill_n <= ill_n + 1;
    if (mode_regs_reset === 1'b1) mrr_n <= mrr_n + 1;
    if (cal_busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_len <= 10'(run);
      ends_n   <= ends_n + 1;
      run      <= 0;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Wide enough for the packed status words below, so no bit is lost
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic frame(input logic [9:0] r, f, input logic sel, en);
    i_dzc_ctrl_model.send(r, f, sel, en);
    repeat (4) @(negedge clk_sys);
  endtask : frame
  task automatic wait_end(input int e);
    int n;
    n = 0;
    while (ends_n == e && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (ends_n == e) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_end
  initial begin
    int i, m, e;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk({cal_busy, training_active, training_remap, mode_regs_reset,
      illegal_cmd, cal_at_default, impedance_ref_pin_en}, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      e = ends_n;
      frame(10'h0A0, cal_tab[k].f, 1'b1, 1'b1);
      wait_end(e);
      @(negedge clk_sys);
      chk(last_len, cal_tab[k].cyc);
      chk(cal_at_default, cal_tab[k].dflt);
      chk(impedance_ref_pin_en, 1'b0);
    end
    i = ill_n;
    m = mrr_n;
    frame(10'h0A0, 10'h2AC, 1'b1, 1'b1);
    frame(10'h0A0, 10'h158, 1'b1, 1'b1);
    chk(16'(ill_n - i), 16'h0001);
    chk(cal_busy, 1'b1);
    frame(10'h3F0, 10'h155, 1'b1, 1'b1);
    chk(16'(mrr_n - m), 16'h0001);
    chk({cal_busy, cal_at_default}, 2'b01);
    banks_open = 1'b1;
    i = ill_n;
    m = mrr_n;
    frame(10'h0A0, 10'h158, 1'b1, 1'b1);
    frame(10'h3F0, 10'h3F0, 1'b1, 1'b1);
    chk(16'(ill_n - i), 16'h0002);
    chk({cal_busy, 16'(mrr_n - m)}, 17'h0_0000);
    banks_open = 1'b0;
    frame(10'h290, 10'h290, 1'b1, 1'b1);
    chk(training_active, 1'b1);
    chk(dq_oe, 16'hFFFF);
    chk({dqs_oe, dqs_o}, 2'b00);
    i = ill_n;
    frame(10'h300, 10'h300, 1'b1, 1'b0);
    chk({training_remap, 16'(ill_n - i)}, 17'h0_0001);
    for (int j = 0; j < 6; j++) begin
      if (tab[j].rm && training_remap !== 1'b1)
        frame(10'h300, 10'h300, 1'b1, 1'b1);
      frame(tab[j].r, tab[j].f, 1'b0, 1'b1);
      chk(dq_o, tab[j].dq);
      chk(training_remap, tab[j].rm);
    end
    frame(10'h2A0, 10'h2A0, 1'b1, 1'b1);
    chk({training_active, dq_o, dq_oe}, 33'h0);
    tally_and_finish();
  end
endmodule : dzc_top_tb

// ==== verilog/dzc_cal_engine.sv ====
// Impedance calibration engine: timer, pin enable, default flag.
// Assumes start is a one-cycle pulse from the decoder on clk_sys.
`timescale 1ns/1ps
module dzc_cal_engine (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  dzc_cal_if.eng    cal,
  output logic      zq_pin_en
);

  logic [dzc_pkg::CNT_W-1:0] cnt_q;
  logic [dzc_pkg::CNT_W-1:0] load_w;
  logic                      busy_q;
  logic                      done_q;
  logic                      at_def_q;
  logic                      zq_en_q;
  dzc_pkg::dzc_cal_kind_t    kind_q;
  wire                       take_w = cal.start && !busy_q;
  wire                       last_w = busy_q && (cnt_q == '0);

  // Each kind has its own completion time
  always_comb begin
    case (cal.kind)
      dzc_pkg::DZC_CAL_INIT:  load_w = dzc_pkg::INIT_IMPEDANCE_CAL_CYC;
      dzc_pkg::DZC_CAL_LONG:  load_w = dzc_pkg::LONG_IMPEDANCE_CAL_CYC;
      dzc_pkg::DZC_CAL_SHORT: load_w = dzc_pkg::SHORT_IMPEDANCE_CAL_CYC;
      default:                load_w = dzc_pkg::IMPEDANCE_CAL_RESET_CYC;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || cal.abort) begin
      cnt_q    <= '0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      at_def_q <= 1'b1;
      zq_en_q  <= 1'b0;
      kind_q   <= dzc_pkg::DZC_CAL_INIT;
    end else begin
      done_q <= last_w;
      if (take_w) begin
        cnt_q   <= load_w - 1'b1;
        busy_q  <= 1'b1;
        zq_en_q <= 1'b1;
        kind_q  <= cal.kind;
      end else if (last_w) begin
        busy_q   <= 1'b0;
        zq_en_q  <= 1'b0;
        at_def_q <= (kind_q == dzc_pkg::DZC_CAL_RESET);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign cal.busy       = busy_q;
  assign cal.done       = done_q;
  assign cal.at_default = at_def_q;
  assign zq_pin_en      = zq_en_q;

endmodule : dzc_cal_engine

// ==== verilog/dzc_cal_if.sv ====
// Carrier between command decoder and calibration engine.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface dzc_cal_if;
  logic                  start;
  logic                  abort;
  dzc_pkg::dzc_cal_kind_t kind;
  logic                  busy;
  logic                  done;
  logic                  at_default;

  modport ctrl (output start, abort, kind, input busy, done, at_default);
  modport eng  (input start, abort, kind, output busy, done, at_default);
endinterface : dzc_cal_if

// ==== verilog/dzc_pkg.sv ====
// Constants, encodings and types for the calibration and CA training block.
// Assumes one 200 MHz system clock samples all memory-bus pins.
package dzc_pkg;

  localparam int unsigned CA_W    = 10;
  localparam int unsigned DQ_W    = 16;
  localparam int unsigned CLK_MHZ = 200;

  // Completion times in ns; plain defaults, not device figures
  localparam int unsigned T_INIT_IMPEDANCE_CAL_NS  = 1000;
  localparam int unsigned T_LONG_IMPEDANCE_CAL_NS    = 360;
  localparam int unsigned T_SHORT_IMPEDANCE_CAL_NS    = 90;
  localparam int unsigned T_IMPEDANCE_CAL_RESET_NS = 50;

  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] INIT_IMPEDANCE_CAL_CYC  =
    CNT_W'((T_INIT_IMPEDANCE_CAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] LONG_IMPEDANCE_CAL_CYC    =
    CNT_W'((T_LONG_IMPEDANCE_CAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] SHORT_IMPEDANCE_CAL_CYC    =
    CNT_W'((T_SHORT_IMPEDANCE_CAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] IMPEDANCE_CAL_RESET_CYC =
    CNT_W'((T_IMPEDANCE_CAL_RESET_NS * CLK_MHZ + 999) / 1000);

  // Command field positions
  localparam int unsigned MRW_OPC_HI = 3;
  localparam logic [3:0]  MRW_OPC    = 4'h0;

  // Mode register addresses and operands
  localparam logic [7:0] MA_TRAIN_ENTRY = 8'h29;
  localparam logic [7:0] OP_TRAIN_ENTRY = 8'hA4;
  localparam logic [7:0] MA_TRAIN_EXIT  = 8'h2A;
  localparam logic [7:0] OP_TRAIN_EXIT  = 8'hA8;
  localparam logic [7:0] MA_TRAIN_REMAP = 8'h30;
  localparam logic [7:0] OP_TRAIN_REMAP = 8'hC0;
  localparam logic [CA_W-1:0] CA_RESET  = 10'h3F0;

  // Calibration command address and operands; plain defaults
  localparam logic [7:0] MA_ZQ       = 8'h0A;
  localparam logic [7:0] OP_ZQ_INIT  = 8'hFF;
  localparam logic [7:0] OP_ZQ_LONG  = 8'hAB;
  localparam logic [7:0] OP_ZQ_SHORT = 8'h56;
  localparam logic [7:0] OP_ZQ_RESET = 8'hC3;

  // Primary session: bit echoed on lane pair 2i, 2i+1
  localparam int unsigned TRAIN_BIT [8] = '{0, 1, 2, 3, 5, 6, 7, 8};
  localparam int unsigned REMAP_BIT_LO  = 4;
  localparam int unsigned REMAP_BIT_HI  = 9;
  localparam int unsigned REMAP_LANE_LO = 0;
  localparam int unsigned REMAP_LANE_HI = 8;

  typedef enum logic [1:0] {
    DZC_CAL_INIT,
    DZC_CAL_LONG,
    DZC_CAL_SHORT,
    DZC_CAL_RESET
  } dzc_cal_kind_t;

  typedef enum logic [1:0] {
    DZC_TR_IDLE,
    DZC_TR_PRIMARY,
    DZC_TR_REMAP
  } dzc_train_t;

endpackage : dzc_pkg

// ==== verilog/dzc_top.sv ====
// Device-side decode of reset, calibration and CA training mode writes.
// Assumes controller keeps its own sequencing duties; link pins are
// asynchronous to clk_sys and are sampled here.
`timescale 1ns/1ps
module dzc_top (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      diff_clock_true,
  input  wire logic                      cs_n,
  input  wire logic                      cke,
  input  wire logic [dzc_pkg::CA_W-1:0]  cmd_addr_bus,
  input  wire logic                      banks_open,
  output logic      [dzc_pkg::DQ_W-1:0]  dq_o,
  output logic      [dzc_pkg::DQ_W-1:0]  dq_oe,
  output logic                           dqs_o,
  output logic                           dqs_oe,
  output logic                           impedance_ref_pin_en,
  output logic                           cal_busy,
  output logic                           cal_at_default,
  output logic                           training_active,
  output logic                           training_remap,
  output logic                           mode_regs_reset,
  output logic                           illegal_cmd
);

  localparam int unsigned CW = dzc_pkg::CA_W;
  localparam int unsigned DW = dzc_pkg::DQ_W;

  // Two-stage synchronisers, plus a third clock stage for edge detection; stage one feeds stage two only
  logic          ck_s1_q, ck_s2_q, ck_s3_q;
  logic          cs_s1_q, cs_s2_q;
  logic          cke_s1_q, cke_s2_q;
  logic [CW-1:0] ca_s1_q, ca_s2_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ck_s1_q  <= 1'b0;
      ck_s2_q  <= 1'b0;
      ck_s3_q  <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cke_s1_q <= 1'b0;
      cke_s2_q <= 1'b0;
      ca_s1_q  <= '0;
      ca_s2_q  <= '0;
    end else begin
      ck_s1_q  <= diff_clock_true;
      ck_s2_q  <= ck_s1_q;
      ck_s3_q  <= ck_s2_q;
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cke_s1_q <= cke;
      cke_s2_q <= cke_s1_q;
      ca_s1_q  <= cmd_addr_bus;
      ca_s2_q  <= ca_s1_q;
    end
  end

  // Irregular link periods are harmless: only edges matter
  wire rise_w = ck_s2_q && !ck_s3_q;
  wire fall_w = !ck_s2_q && ck_s3_q;

  // Rising-edge half of a command, completed at the falling edge
  logic [CW-1:0] ca_r_q;
  logic          cs_r_q;
  logic          cke_r_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ca_r_q  <= '0;
      cs_r_q  <= 1'b1;
      cke_r_q <= 1'b0;
    end else if (rise_w) begin
      ca_r_q  <= ca_s2_q;
      cs_r_q  <= cs_s2_q;
      cke_r_q <= cke_s2_q;
    end
  end

  // Command decode on the falling edge
  wire [CW-1:0] ca_f_w = ca_s2_q;
  wire          mrw_w  = fall_w && !cs_r_q &&
                 (ca_r_q[dzc_pkg::MRW_OPC_HI:0] == dzc_pkg::MRW_OPC);
  wire [7:0]    ma_w   = {ca_f_w[1:0], ca_r_q[9:4]};
  wire [7:0]    op_w   = ca_f_w[9:2];

  // Second edge is don't-care for the reset form
  wire is_reset_w = mrw_w && (ca_r_q == dzc_pkg::CA_RESET);
  // Same value on both edges, so no CA deskew needed
  wire is_entry_w = mrw_w && (ma_w == dzc_pkg::MA_TRAIN_ENTRY) &&
                    (op_w == dzc_pkg::OP_TRAIN_ENTRY);
  wire is_exit_w  = mrw_w && (ma_w == dzc_pkg::MA_TRAIN_EXIT) &&
                    (op_w == dzc_pkg::OP_TRAIN_EXIT);
  wire is_remap_w = mrw_w && (ma_w == dzc_pkg::MA_TRAIN_REMAP) &&
                    (op_w == dzc_pkg::OP_TRAIN_REMAP);
  wire op_init_w  = op_w == dzc_pkg::OP_ZQ_INIT;
  wire op_long_w  = op_w == dzc_pkg::OP_ZQ_LONG;
  wire op_short_w = op_w == dzc_pkg::OP_ZQ_SHORT;
  wire op_zrst_w  = op_w == dzc_pkg::OP_ZQ_RESET;
  wire is_zq_w    = mrw_w && (ma_w == dzc_pkg::MA_ZQ) &&
                    (op_init_w || op_long_w || op_short_w || op_zrst_w);

  dzc_cal_if cal ();

  dzc_cal_engine u_cal (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .cal       (cal.eng),
    .zq_pin_en (impedance_ref_pin_en)
  );

  dzc_pkg::dzc_train_t tr_q, tr_d;
  wire in_train_w = (tr_q != dzc_pkg::DZC_TR_IDLE);

  // Open banks or busy engine reject calibration untouched
  wire zq_bad_w  = is_zq_w && (banks_open || cal.busy || in_train_w);
  wire zq_go_w   = is_zq_w && !zq_bad_w;
  // Mode writes with open banks are refused outside training
  wire rst_bad_w = is_reset_w && banks_open;
  wire rst_go_w  = is_reset_w && !banks_open && !in_train_w;
  wire mrw_bad_w = mrw_w && banks_open && !in_train_w;
  // Remap needs clock enable high at its rising edge
  wire remap_ok_w = is_remap_w && cke_r_q;

  dzc_pkg::dzc_cal_kind_t kind_w;
  assign kind_w = op_init_w  ? dzc_pkg::DZC_CAL_INIT  :
                  op_long_w  ? dzc_pkg::DZC_CAL_LONG  :
                  op_short_w ? dzc_pkg::DZC_CAL_SHORT :
                               dzc_pkg::DZC_CAL_RESET;

  // Training sequence: entry, primary, remap, exit
  always_comb begin
    tr_d = tr_q;
    case (tr_q)
      dzc_pkg::DZC_TR_IDLE:
        if (is_entry_w && !banks_open && !cal.busy)
          tr_d = dzc_pkg::DZC_TR_PRIMARY;
      dzc_pkg::DZC_TR_PRIMARY: begin
        if (remap_ok_w)
          tr_d = dzc_pkg::DZC_TR_REMAP;
        else if (is_exit_w)
          tr_d = dzc_pkg::DZC_TR_IDLE;
      end
      dzc_pkg::DZC_TR_REMAP:
        if (is_exit_w)
          tr_d = dzc_pkg::DZC_TR_IDLE;
      default:
        tr_d = dzc_pkg::DZC_TR_IDLE;
    endcase
  end

  // Echo lanes; entry, exit and accepted remap writes are not echoed
  wire          echo_w = fall_w && in_train_w && !is_exit_w &&
                         !remap_ok_w && !is_entry_w;
  logic [DW-1:0] prim_w;
  logic [DW-1:0] remap_w;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lane
      assign prim_w[2*gi]   = ca_r_q[dzc_pkg::TRAIN_BIT[gi]];
      assign prim_w[2*gi+1] = ca_f_w[dzc_pkg::TRAIN_BIT[gi]];
    end
  endgenerate

  // Unused lanes parked low: a valid level, never floating
  always_comb begin
    remap_w = '0;
    remap_w[dzc_pkg::REMAP_LANE_LO]   = ca_r_q[dzc_pkg::REMAP_BIT_LO];
    remap_w[dzc_pkg::REMAP_LANE_LO+1] = ca_f_w[dzc_pkg::REMAP_BIT_LO];
    remap_w[dzc_pkg::REMAP_LANE_HI]   = ca_r_q[dzc_pkg::REMAP_BIT_HI];
    remap_w[dzc_pkg::REMAP_LANE_HI+1] = ca_f_w[dzc_pkg::REMAP_BIT_HI];
  end

  logic [DW-1:0] dq_q;
  logic          dq_en_q;
  logic          mrr_q;
  logic          remap_q;
  logic          ill_q;
  logic          start_q;
  logic          abort_q;
  dzc_pkg::dzc_cal_kind_t kind_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tr_q <= dzc_pkg::DZC_TR_IDLE;
    end else if (rst_go_w) begin
      tr_q <= dzc_pkg::DZC_TR_IDLE;
    end else begin
      tr_q <= tr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dq_q    <= '0;
      dq_en_q <= 1'b0;
      remap_q <= 1'b0;
    end else begin
      dq_en_q <= (tr_d != dzc_pkg::DZC_TR_IDLE) && !rst_go_w;
      remap_q <= (tr_d == dzc_pkg::DZC_TR_REMAP) && !rst_go_w;
      if (tr_d == dzc_pkg::DZC_TR_IDLE)
        dq_q <= '0;
      else if (echo_w)
        dq_q <= (tr_q == dzc_pkg::DZC_TR_REMAP) ? remap_w : prim_w;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mrr_q   <= 1'b0;
      ill_q   <= 1'b0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      kind_q  <= dzc_pkg::DZC_CAL_INIT;
    end else begin
      mrr_q   <= rst_go_w;
      ill_q   <= zq_bad_w || rst_bad_w || mrw_bad_w
                 || (is_remap_w && !cke_r_q);
      start_q <= zq_go_w;
      abort_q <= rst_go_w; // Reset also restores calibration default
      if (zq_go_w)
        kind_q <= kind_w;
    end
  end

  assign cal.start = start_q;
  assign cal.abort = abort_q;
  assign cal.kind  = kind_q;

  // Strobe held static and undriven through training
  assign dqs_o           = 1'b0;
  assign dqs_oe          = 1'b0;
  assign dq_o            = dq_q;
  assign dq_oe           = {DW{dq_en_q}};
  assign cal_busy        = cal.busy;
  assign cal_at_default  = cal.at_default;
  assign training_active = dq_en_q;
  assign training_remap  = remap_q;
  assign mode_regs_reset = mrr_q;
  assign illegal_cmd     = ill_q;

endmodule : dzc_top
